/* File: src/pfs_defines.vh */
// constants for the pad function select block
`ifndef PFS_DEFINES_VH
`define PFS_DEFINES_VH
`define PFS_OFF_CFG_BASE  12'h000
`define PFS_OFF_SRCSEL    12'h400
`define PFS_OFF_CTRL      12'h404
`define PFS_OFF_STATUS    12'h408
`define PFS_OFF_PADIN     12'h40c
`define PFS_ALT_F0        3'h0
`define PFS_ALT_F1        3'h1
`define PFS_ALT_F2        3'h2
`define PFS_ALT_F3        3'h3
`define PFS_ALT_F4        3'h4
`define PFS_CFG_ALT_LSB   0
`define PFS_CFG_IBE_BIT   3
`define PFS_CFG_OBE_BIT   4
`define PFS_CFG_PUE_BIT   5
`define PFS_CFG_PUS_BIT   6
`define PFS_CFG_NMI_BIT   7
`define PFS_CFG_SLEW_LSB  8
`define PFS_CFG_SUP_BIT   10
`define PFS_CFG_W         11
`define PFS_CFG_RST       11'h000
`define PFS_CFG_RST_JTAG  11'h008
`define PFS_SRCSEL_RST    32'h00000000
`define PFS_RESP_OKAY     2'h0
`define PFS_RESP_SLVERR   2'h2
`endif

/* File: src/pfs_sync2.v */
// two flip-flop synchroniser for a vector of pad inputs
`default_nettype none
module pfs_sync2 #(
  parameter W = 8
) (
  input  wire         clk,
  input  wire         rst_n,
  input  wire [W-1:0] d,
  output reg  [W-1:0] q
);
  reg [W-1:0] meta_r;
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_r <= {W{1'b0}};
      q      <= {W{1'b0}};
    end else begin
      meta_r <= d;
      q      <= meta_r;
    end
  end
endmodule // pfs_sync2
`default_nettype wire

/* File: src/pfs_cfg_mem.v */
// per-pad configuration store, registered read port
`include "pfs_defines.vh"
`default_nettype none
module pfs_cfg_mem #(
  parameter N  = 8,
  parameter AW = 3,
  parameter W  = 11
) (
  input  wire          clk,
  input  wire          rst_n,
  input  wire          we,
  input  wire [AW-1:0] waddr,
  input  wire [W-1:0]  wdata,
  input  wire [AW-1:0] raddr,
  output reg  [W-1:0]  rdata,
  output wire [N*W-1:0] all_cfg
);
  reg [W-1:0] cfg_r [0:N-1];
  genvar g;
  generate
    for (g = 0; g < N; g = g + 1) begin : g_pad
      // jtag pads sit at indices 0..3 and default to input-enabled
      always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          cfg_r[g] <= (g < 4) ? `PFS_CFG_RST_JTAG : `PFS_CFG_RST;
        end else if (we && waddr == g) begin
          cfg_r[g] <= wdata;
        end
      end
      assign all_cfg[g*W +: W] = cfg_r[g];
    end
  endgenerate
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata <= {W{1'b0}};
    end else begin
      rdata <= cfg_r[raddr];
    end
  end
endmodule // pfs_cfg_mem
`default_nettype wire

/* File: src/pfs_top.v */
// pad function select: per-pad output mux, input gating and pad defaults
`include "pfs_defines.vh"
`default_nettype none
module pfs_top #(
  parameter N_PADS = 32,
  parameter AW     = 5
) (
  input  wire                REF_CLK,
  input  wire                RST_N,
  input  wire                S_AXI_AWVALID,
  output reg                 S_AXI_AWREADY,
  input  wire [11:0]         S_AXI_AWADDR,
  input  wire                S_AXI_WVALID,
  output reg                 S_AXI_WREADY,
  input  wire [31:0]         S_AXI_WDATA,
  input  wire [3:0]          S_AXI_WSTRB,
  output reg                 S_AXI_BVALID,
  input  wire                S_AXI_BREADY,
  output reg  [1:0]          S_AXI_BRESP,
  input  wire                S_AXI_ARVALID,
  output reg                 S_AXI_ARREADY,
  input  wire [11:0]         S_AXI_ARADDR,
  output reg                 S_AXI_RVALID,
  input  wire                S_AXI_RREADY,
  output reg  [31:0]         S_AXI_RDATA,
  output reg  [1:0]          S_AXI_RRESP,
  input  wire [N_PADS*5-1:0] FUNC_OUT,
  input  wire [N_PADS-1:0]   NMI_OUT,
  input  wire [N_PADS-1:0]   PAD_IN,
  output reg  [N_PADS-1:0]   PAD_OUT,
  output reg  [N_PADS-1:0]   PAD_OE_N,
  output reg  [N_PADS-1:0]   PAD_PULL_EN,
  output reg  [N_PADS-1:0]   PAD_PULL_UP,
  output reg  [N_PADS*2-1:0] PAD_DRIVE,
  output reg  [N_PADS-1:0]   PAD_SUPPLY_SEL,
  output reg  [N_PADS-1:0]   PERIPH_IN,
  output reg  [3:0]          SHARED_IN,
  input  wire                SELFTEST_EN,
  input  wire                POWERUP_N,
  input  wire [11:0]         TRACE_DATA,
  input  wire                TRACE_MSG,
  input  wire                TRACE_CLK,
  input  wire                DBG_TRACE_CLK_EN,
  input  wire                DBG_PROC_STAT_EN,
  input  wire                DBG_FULL_PORT,
  input  wire [N_PADS-1:0]   XTAL_PAD_MASK,
  output reg  [13:0]         TRACE_OE_N,
  output reg  [13:0]         TRACE_PAD_OUT
);
  localparam W = `PFS_CFG_W;

  // synchronised pad, debugger and power-up inputs
  wire [N_PADS-1:0] pad_in_s;
  wire [3:0]        ctl_s;
  pfs_sync2 #(.W(N_PADS)) u_pad_sync (
    .clk   (REF_CLK),
    .rst_n (RST_N),
    .d     (PAD_IN),
    .q     (pad_in_s)
  );
  pfs_sync2 #(.W(4)) u_ctl_sync (
    .clk   (REF_CLK),
    .rst_n (RST_N),
    .d     ({DBG_FULL_PORT, DBG_PROC_STAT_EN, DBG_TRACE_CLK_EN, POWERUP_N}),
    .q     (ctl_s)
  );
  wire pwr_ok_s = ctl_s[0];

  // axi write channel
  reg        aw_got_r;
  reg        w_got_r;
  reg [11:0] awaddr_r;
  reg [31:0] wdata_r;
  reg [3:0]  wstrb_r;
  reg [31:0] srcsel_r;
  reg [1:0]  ctrl_r;
  wire       wr_go = aw_got_r && w_got_r && !S_AXI_BVALID;
  wire       wr_cfg = awaddr_r < (N_PADS * 4);
  wire [W-1:0] cfg_rd;
  wire [N_PADS*W-1:0] all_cfg;
  wire [W-1:0] wmerge;
  reg        wr_ph_r;
  reg [11:0] ar_addr_q;
  reg        ar_got_r;
  reg        rd_ph_r;
  reg        rd_ph2_r;

  function [W-1:0] strb_merge;
    input [W-1:0] old;
    input [31:0]  nw;
    input [3:0]   st;
    reg   [15:0]  t;
    begin
      t = {(st[1] ? nw[15:8] : {5'h00, old[10:8]}), (st[0] ? nw[7:0] : old[7:0])};
      strb_merge = t[W-1:0];
    end
  endfunction

  pfs_cfg_mem #(.N(N_PADS), .AW(AW), .W(W)) u_cfg (
    .clk     (REF_CLK),
    .rst_n   (RST_N),
    .we      (wr_go && wr_ph_r && wr_cfg),
    .waddr   (awaddr_r[AW+1:2]),
    .wdata   (wmerge),
    .raddr   (ar_got_r ? ar_addr_q[AW+1:2] : awaddr_r[AW+1:2]),
    .rdata   (cfg_rd),
    .all_cfg (all_cfg)
  );
  // read-modify uses the registered word, so writes wait one cycle for it
  assign wmerge = strb_merge(cfg_rd, wdata_r, wstrb_r);

  always @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      S_AXI_AWREADY <= 1'b0;
      S_AXI_WREADY  <= 1'b0;
      S_AXI_BVALID  <= 1'b0;
      S_AXI_BRESP   <= `PFS_RESP_OKAY;
      aw_got_r      <= 1'b0;
      w_got_r       <= 1'b0;
      awaddr_r      <= 12'h000;
      wdata_r       <= 32'h00000000;
      wstrb_r       <= 4'h0;
      srcsel_r      <= `PFS_SRCSEL_RST;
      ctrl_r        <= 2'h0;
      wr_ph_r       <= 1'b0;
    end else begin
      S_AXI_AWREADY <= !aw_got_r && !S_AXI_AWREADY && S_AXI_AWVALID;
      S_AXI_WREADY  <= !w_got_r && !S_AXI_WREADY && S_AXI_WVALID;
      if (S_AXI_AWREADY && S_AXI_AWVALID) begin
        aw_got_r <= 1'b1;
        awaddr_r <= S_AXI_AWADDR;
      end
      if (S_AXI_WREADY && S_AXI_WVALID) begin
        w_got_r <= 1'b1;
        wdata_r <= S_AXI_WDATA;
        wstrb_r <= S_AXI_WSTRB;
      end
      // a read in flight owns the memory port, so the merge waits for it
      if (aw_got_r && w_got_r && !S_AXI_BVALID && !wr_ph_r && !ar_got_r) begin
        wr_ph_r <= 1'b1;
      end
      if (wr_go && wr_ph_r) begin
        wr_ph_r      <= 1'b0;
        aw_got_r     <= 1'b0;
        w_got_r      <= 1'b0;
        S_AXI_BVALID <= 1'b1;
        S_AXI_BRESP  <= `PFS_RESP_OKAY;
        if (awaddr_r == `PFS_OFF_SRCSEL) begin
          srcsel_r <= wstrb_r == 4'h0 ? srcsel_r : wdata_r;
        end else if (awaddr_r == `PFS_OFF_CTRL) begin
          ctrl_r <= wstrb_r[0] ? wdata_r[1:0] : ctrl_r;
        end else if (!wr_cfg) begin
          S_AXI_BRESP <= `PFS_RESP_SLVERR;
        end
      end
      if (S_AXI_BVALID && S_AXI_BREADY) begin
        S_AXI_BVALID <= 1'b0;
      end
    end
  end

  // axi read channel: address taken, one cycle for memory, then data
  always @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      S_AXI_ARREADY <= 1'b0;
      S_AXI_RVALID  <= 1'b0;
      S_AXI_RDATA   <= 32'h00000000;
      S_AXI_RRESP   <= `PFS_RESP_OKAY;
      ar_addr_q     <= 12'h000;
      ar_got_r      <= 1'b0;
      rd_ph_r       <= 1'b0;
      rd_ph2_r      <= 1'b0;
    end else begin
      S_AXI_ARREADY <= !ar_got_r && !S_AXI_ARREADY && S_AXI_ARVALID && !wr_ph_r;
      rd_ph_r       <= 1'b0;
      rd_ph2_r      <= rd_ph_r;
      if (S_AXI_ARREADY && S_AXI_ARVALID) begin
        ar_got_r  <= 1'b1;
        ar_addr_q <= S_AXI_ARADDR;
        rd_ph_r   <= 1'b1;
      end
      if (rd_ph2_r) begin
        S_AXI_RVALID <= 1'b1;
        S_AXI_RRESP  <= `PFS_RESP_OKAY;
        if (ar_addr_q < (N_PADS * 4)) begin
          S_AXI_RDATA <= {{(32-W){1'b0}}, cfg_rd};
        end else if (ar_addr_q == `PFS_OFF_SRCSEL) begin
          S_AXI_RDATA <= srcsel_r;
        end else if (ar_addr_q == `PFS_OFF_CTRL) begin
          S_AXI_RDATA <= {30'h0, ctrl_r};
        end else if (ar_addr_q == `PFS_OFF_STATUS) begin
          S_AXI_RDATA <= {28'h0, ctl_s[3:1], pwr_ok_s};
        end else if (ar_addr_q == `PFS_OFF_PADIN) begin
          S_AXI_RDATA <= pad_in_s;
        end else begin
          S_AXI_RDATA <= 32'h00000000;
          S_AXI_RRESP <= `PFS_RESP_SLVERR;
        end
      end
      if (S_AXI_RVALID && S_AXI_RREADY) begin
        S_AXI_RVALID <= 1'b0;
        ar_got_r     <= 1'b0;
      end
    end
  end

  // per-pad output mux and input gating
  function [4:0] alt_decode;
    input [2:0] a;
    begin
      case (a)
        `PFS_ALT_F0: alt_decode = 5'h01;
        `PFS_ALT_F1: alt_decode = 5'h02;
        `PFS_ALT_F2: alt_decode = 5'h04;
        `PFS_ALT_F3: alt_decode = 5'h08;
        `PFS_ALT_F4: alt_decode = 5'h10;
        default:     alt_decode = 5'h00;
      endcase
    end
  endfunction

  reg [N_PADS-1:0]   out_nxt;
  reg [N_PADS-1:0]   oe_n_nxt;
  reg [N_PADS-1:0]   in_nxt;
  reg [N_PADS-1:0]   pe_nxt;
  reg [N_PADS-1:0]   pu_nxt;
  reg [N_PADS*2-1:0] drv_nxt;
  reg [N_PADS-1:0]   sup_nxt;
  reg [W-1:0]        c;
  reg [4:0]          sel;
  integer            i;

  always @* begin
    out_nxt  = {N_PADS{1'b0}};
    oe_n_nxt = {N_PADS{1'b1}};
    in_nxt   = {N_PADS{1'b0}};
    pe_nxt   = {N_PADS{1'b0}};
    pu_nxt   = {N_PADS{1'b0}};
    drv_nxt  = {N_PADS*2{1'b0}};
    sup_nxt  = {N_PADS{1'b0}};
    c        = {W{1'b0}};
    sel      = 5'h00;
    for (i = 0; i < N_PADS; i = i + 1) begin
      c   = all_cfg[i*W +: W];
      sel = alt_decode(c[`PFS_CFG_ALT_LSB +: 3]);
      if (c[`PFS_CFG_NMI_BIT]) begin
        out_nxt[i] = NMI_OUT[i];
      end else begin
        out_nxt[i] = |(sel & FUNC_OUT[i*5 +: 5]);
      end
      // output only when enabled, a function or nmi chosen, supply up, not crystal
      oe_n_nxt[i] = !(c[`PFS_CFG_OBE_BIT] && (|sel || c[`PFS_CFG_NMI_BIT])
                      && pwr_ok_s && !XTAL_PAD_MASK[i]);
      in_nxt[i]  = c[`PFS_CFG_IBE_BIT] & pad_in_s[i];
      pe_nxt[i]  = c[`PFS_CFG_PUE_BIT] & !XTAL_PAD_MASK[i];
      pu_nxt[i]  = c[`PFS_CFG_PUS_BIT];
      drv_nxt[i*2 +: 2] = c[`PFS_CFG_SLEW_LSB +: 2];
      sup_nxt[i] = c[`PFS_CFG_SUP_BIT] | !pwr_ok_s;
    end
  end

  // shared peripheral inputs picked by 8-bit pad-select fields
  reg [3:0] shared_nxt;
  integer   k;
  always @* begin
    shared_nxt = 4'h0;
    for (k = 0; k < 4; k = k + 1) begin
      shared_nxt[k] = in_nxt[srcsel_r[k*8 +: AW]];
    end
  end

  // trace pad claims by the debugger port
  wire clk_en = ctl_s[1];
  wire st_en  = ctl_s[2];
  wire full_port_mode    = ctl_s[3];
  wire low_claim  = clk_en | st_en;
  wire high_claim = (clk_en & full_port_mode) | st_en;

  always @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      PAD_OUT        <= {N_PADS{1'b0}};
      PAD_OE_N       <= {N_PADS{1'b1}};
      PAD_PULL_EN    <= {N_PADS{1'b0}};
      PAD_PULL_UP    <= {N_PADS{1'b0}};
      PAD_DRIVE      <= {N_PADS*2{1'b0}};
      PAD_SUPPLY_SEL <= {N_PADS{1'b0}};
      PERIPH_IN      <= {N_PADS{1'b0}};
      SHARED_IN      <= 4'h0;
    end else begin
      PAD_OUT        <= out_nxt;
      PAD_OE_N       <= oe_n_nxt;
      PAD_PULL_EN    <= pe_nxt;
      PAD_PULL_UP    <= pu_nxt;
      PAD_DRIVE      <= drv_nxt;
      PAD_SUPPLY_SEL <= sup_nxt;
      PERIPH_IN      <= in_nxt;
      SHARED_IN      <= shared_nxt;
    end
  end

  // reset-free chains: the self-test pin and reset level must be seen in reset
  reg rst_meta_r;
  reg rst_s_r;
  reg st_meta_r;
  reg st_s_r;
  always @(posedge REF_CLK) begin
    rst_meta_r <= RST_N;
    rst_s_r    <= rst_meta_r;
    st_meta_r  <= SELFTEST_EN;
    st_s_r     <= st_meta_r;
  end

  // trace pads follow reset two cycles late, traded for a registered indicator
  always @(posedge REF_CLK) begin
    if (!rst_s_r) begin
      TRACE_OE_N    <= {13'h1fff, !st_s_r};
      TRACE_PAD_OUT <= {13'h0000, st_s_r};
    end else begin
      TRACE_OE_N    <= ~{low_claim, low_claim, {4{high_claim}}, {8{low_claim}}};
      TRACE_PAD_OUT <= {TRACE_CLK, TRACE_MSG, TRACE_DATA};
    end
  end
endmodule // pfs_top
`default_nettype wire

/* File: tb/pfs_pad_model.sv */
// pad level model: a driven pad shows the block's output, otherwise the outside level
`default_nettype none
module pfs_pad_model #(
  parameter int N = 32
) (
  input  wire logic [N-1:0] PAD_OUT,
  input  wire logic [N-1:0] PAD_OE_N,
  input  wire logic [N-1:0] ext_lvl,
  output wire logic [N-1:0] pad_lvl
);
  // outside driver always present, so an undriven pad never floats to x
  assign pad_lvl = (~PAD_OE_N & PAD_OUT) | (PAD_OE_N & ext_lvl);
endmodule // pfs_pad_model
`default_nettype wire

/* File: tb/pfs_asserts.sv */
// concurrent checks on the pad function select ports
`default_nettype none
module pfs_asserts #(
  parameter N_PADS = 32
) (
  input wire logic              REF_CLK,
  input wire logic              RST_N,
  input wire logic [N_PADS-1:0] PAD_OE_N,
  input wire logic [N_PADS-1:0] PAD_PULL_EN,
  input wire logic [N_PADS-1:0] PAD_SUPPLY_SEL,
  input wire logic [N_PADS-1:0] PAD_IN,
  input wire logic [N_PADS-1:0] PERIPH_IN,
  input wire logic [N_PADS-1:0] XTAL_PAD_MASK,
  input wire logic              POWERUP_N,
  input wire logic              SELFTEST_EN,
  input wire logic              DBG_TRACE_CLK_EN,
  input wire logic              DBG_PROC_STAT_EN,
  input wire logic              DBG_FULL_PORT,
  input wire logic [13:0]       TRACE_OE_N,
  input wire logic [13:0]       TRACE_PAD_OUT
);
  default clocking cb @(posedge REF_CLK); endclocking
  // debugger bits cross two sync stages plus one register
  sequence s_lo_on;  (DBG_TRACE_CLK_EN | DBG_PROC_STAT_EN) [*5]; endsequence
  sequence s_lo_off; !(DBG_TRACE_CLK_EN | DBG_PROC_STAT_EN) [*5]; endsequence
  sequence s_hi_on;  ((DBG_TRACE_CLK_EN & DBG_FULL_PORT) | DBG_PROC_STAT_EN) [*5]; endsequence
  sequence s_hi_off; !((DBG_TRACE_CLK_EN & DBG_FULL_PORT) | DBG_PROC_STAT_EN) [*5]; endsequence
  property p_rst_off;
    disable iff (!RST_N) $rose(RST_N) |-> PAD_OE_N == '1 && PAD_PULL_EN == '0;
  endproperty
  property p_xtal;
    disable iff (!RST_N) $stable(XTAL_PAD_MASK) |-> (XTAL_PAD_MASK & (~PAD_OE_N | PAD_PULL_EN)) == '0;
  endproperty
  property p_pwrup;
    disable iff (!RST_N) !POWERUP_N [*4] |-> PAD_OE_N == '1 && PAD_SUPPLY_SEL == '1;
  endproperty
  property p_in_gate;
    disable iff (!RST_N) $stable(PAD_IN) [*4] |-> (PERIPH_IN & ~PAD_IN) == '0;
  endproperty
  property p_lo_on;
    disable iff (!RST_N) s_lo_on |-> TRACE_OE_N[7:0] == 8'h00 && TRACE_OE_N[13:12] == 2'h0;
  endproperty
  property p_lo_off;
    disable iff (!RST_N) s_lo_off |-> TRACE_OE_N[7:0] == 8'hff;
  endproperty
  property p_hi_on;
    disable iff (!RST_N) s_hi_on |-> TRACE_OE_N[11:8] == 4'h0;
  endproperty
  property p_hi_off;
    disable iff (!RST_N) s_hi_off |-> TRACE_OE_N[11:8] == 4'hf;
  endproperty
  property p_st_on;
    (!RST_N && SELFTEST_EN) [*5] |-> !TRACE_OE_N[0] && TRACE_PAD_OUT[0];
  endproperty
  property p_st_off;
    (!RST_N && !SELFTEST_EN) [*5] |-> TRACE_OE_N[0];
  endproperty
  a_rst_off: assert property (p_rst_off) else $error("pad driven after reset");
  a_xtal: assert property (p_xtal) else $error("crystal pad driven or pulled");
  a_pwrup: assert property (p_pwrup) else $error("pad active in power-up");
  a_in_gate: assert property (p_in_gate) else $error("input not from pad");
  a_lo_on: assert property (p_lo_on) else $error("low trace pads not claimed");
  a_lo_off: assert property (p_lo_off) else $error("low trace pads claimed");
  a_hi_on: assert property (p_hi_on) else $error("high trace pads not claimed");
  a_hi_off: assert property (p_hi_off) else $error("high trace pads claimed");
  a_st_on: assert property (p_st_on) else $error("self-test pad not high");
  a_st_off: assert property (p_st_off) else $error("self-test pad driven");
endmodule // pfs_asserts
bind pfs_top pfs_asserts #(.N_PADS(N_PADS)) i_chk (.*);
`default_nettype wire

/* File: tb/tb.sv */
// self-checking bench for the pad function select block
`include "pfs_defines.vh"
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int N = 32;
  logic REF_CLK = 0, RST_N = 0, SELFTEST_EN = 0, POWERUP_N = 1, TRACE_MSG = 0, TRACE_CLK = 0;
  logic DBG_TRACE_CLK_EN = 0, DBG_PROC_STAT_EN = 0, DBG_FULL_PORT = 0;
  logic S_AXI_AWVALID = 0, S_AXI_WVALID = 0, S_AXI_BREADY = 0, S_AXI_ARVALID = 0;
  logic S_AXI_RREADY = 0;
  logic [11:0] S_AXI_AWADDR = 0, S_AXI_ARADDR = 0, TRACE_DATA = 0;
  logic [31:0] S_AXI_WDATA = 0, rd;
  logic [3:0] S_AXI_WSTRB = 0;
  logic [N*5-1:0] FUNC_OUT = 0;
  logic [N-1:0] NMI_OUT = 0, XTAL_PAD_MASK = 0, ext = 0;
  logic [1:0] rsp;
  wire S_AXI_AWREADY, S_AXI_WREADY, S_AXI_BVALID, S_AXI_ARREADY, S_AXI_RVALID;
  wire [1:0] S_AXI_BRESP, S_AXI_RRESP;
  wire [31:0] S_AXI_RDATA;
  wire [N-1:0] PAD_IN, PAD_OUT, PAD_OE_N, PAD_PULL_EN, PAD_PULL_UP, PAD_SUPPLY_SEL, PERIPH_IN;
  wire [N*2-1:0] PAD_DRIVE;
  wire [3:0] SHARED_IN;
  wire [13:0] TRACE_OE_N, TRACE_PAD_OUT;
  int num_errors = 0, tests_run = 0, cfg[N];
  pfs_top i_dut (.*);
  pfs_pad_model #(.N(N)) i_pad (.PAD_OUT(PAD_OUT), .PAD_OE_N(PAD_OE_N), .ext_lvl(ext),
    .pad_lvl(PAD_IN));
  always #25 REF_CLK = ~REF_CLK;
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %0t seen %h exp %h", $time, seen, exp);
    end
  endtask
  task summarize;
    if (num_errors == 0 && tests_run > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge REF_CLK);
    S_AXI_AWADDR <= a; S_AXI_WDATA <= d; S_AXI_WSTRB <= 4'hf;
    S_AXI_AWVALID <= 1; S_AXI_WVALID <= 1; S_AXI_BREADY <= 1;
    do begin
      @(posedge REF_CLK);
      if (S_AXI_AWREADY === 1'b1) S_AXI_AWVALID <= 0;
      if (S_AXI_WREADY === 1'b1) S_AXI_WVALID <= 0;
    end while (S_AXI_BVALID !== 1'b1);
    S_AXI_BREADY <= 0;
    rsp = S_AXI_BRESP;
  endtask
  task rdr(input logic [11:0] a);
    @(posedge REF_CLK);
    S_AXI_ARADDR <= a; S_AXI_ARVALID <= 1; S_AXI_RREADY <= 1;
    do begin
      @(posedge REF_CLK);
      if (S_AXI_ARREADY === 1'b1) S_AXI_ARVALID <= 0;
    end while (S_AXI_RVALID !== 1'b1);
    S_AXI_RREADY <= 0;
    rd = S_AXI_RDATA;
    rsp = S_AXI_RRESP;
  endtask
  // one register of latency on pad outputs, two more on synchronised inputs
  task setp(input int p, input logic [10:0] v);
    cfg[p] = v;
    wr(12'(p * 4), {21'h0, v});
    repeat (4) @(posedge REF_CLK);
  endtask
  initial begin
    #(5000 * 50);
    num_errors++;
    summarize();
  end
  initial begin
    void'($urandom(32'h4a9b8f7e));
    foreach (cfg[p]) cfg[p] = (p < 4) ? `PFS_CFG_RST_JTAG : `PFS_CFG_RST;
    repeat (16) @(posedge REF_CLK);
    RST_N <= 1;
    @(posedge REF_CLK);
    chk(PAD_OE_N, '1);
    for (int p = 0; p < 6; p++) begin
      rdr(12'(p * 4));
      chk(rd, cfg[p]);
    end
    for (int a = 0; a < 8; a++) begin
      FUNC_OUT <= {$urandom(), $urandom(), $urandom(), $urandom(), $urandom()};
      setp(8, 11'h010 | a);
      chk(PAD_OE_N[8], a > 4);
      if (a < 5) chk(PAD_OUT[8], FUNC_OUT[40+a]);
    end
    for (int k = 0; k < 2; k++) begin
      NMI_OUT <= {N{k[0]}};
      setp(8, 11'h092);
      chk(PAD_OUT[8], k);
    end
    XTAL_PAD_MASK <= 32'h100;
    setp(8, 11'h030);
    chk({PAD_OE_N[8], PAD_PULL_EN[8]}, 2'h2);
    XTAL_PAD_MASK <= 0;
    for (int d = 0; d < 3; d++) begin
      setp(10, 11'h020 | (d[0] << 6) | (d << 8));
      chk({PAD_DRIVE[21:20], PAD_PULL_EN[10], PAD_PULL_UP[10]}, {d[1:0], 1'b1, d[0]});
    end
    ext <= $urandom();
    setp(9, 11'h000);
    chk(PERIPH_IN[9], 0);
    setp(9, 11'h00a);
    chk(PERIPH_IN[9], ext[9]);
    wr(`PFS_OFF_SRCSEL, 32'h03020109);
    chk(rsp, `PFS_RESP_OKAY);
    repeat (4) @(posedge REF_CLK);
    chk(SHARED_IN, {ext[3], ext[2], ext[1], ext[9]});
    chk(PERIPH_IN[3:0], ext[3:0]);
    rdr(12'h800);
    chk({rsp, rd}, {`PFS_RESP_SLVERR, 32'h0});
    for (int i = 0; i < 8; i++) begin
      {DBG_FULL_PORT, DBG_PROC_STAT_EN, DBG_TRACE_CLK_EN} <= 3'(i);
      repeat (6) @(posedge REF_CLK);
      chk(TRACE_OE_N[7:0], (i[0] | i[1]) ? 8'h00 : 8'hff);
      chk(TRACE_OE_N[11:8], ((i[0] & i[2]) | i[1]) ? 4'h0 : 4'hf);
    end
    {DBG_FULL_PORT, DBG_PROC_STAT_EN, DBG_TRACE_CLK_EN} <= 3'h0;
    POWERUP_N <= 0;
    repeat (6) @(posedge REF_CLK);
    chk({PAD_SUPPLY_SEL, PAD_OE_N}, {64{1'b1}});
    POWERUP_N <= 1;
    RST_N <= 0;
    SELFTEST_EN <= 1;
    repeat (5) @(posedge REF_CLK);
    chk({TRACE_OE_N[0], TRACE_PAD_OUT[0]}, 2'h1);
    SELFTEST_EN <= 0;
    repeat (5) @(posedge REF_CLK);
    chk(TRACE_OE_N[0], 1);
    RST_N <= 1;
    repeat (3) @(posedge REF_CLK);
    summarize();
  end
endmodule // tb
`default_nettype wire
